// ===== verilog/fsp_regs.vh
/*
 * constants of the flash status/suspend/protect host controller:
 * command bytes, unlock pattern, status bit positions, own register map
 * and bus timing counts.
 * assumes: included by the controller file and the bench, by its bare name.
 */
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// own register map (word index on the plain port)
`define FSP_REG_CTRL     4'h0
`define FSP_REG_ADDR     4'h1
`define FSP_REG_WDATA    4'h2
`define FSP_REG_STATUS   4'h3
`define FSP_REG_RDATA    4'h4
`define FSP_REG_FLAGS    4'h5

// operation codes written to the control register
`define FSP_OP_READ_ARRAY  4'h1
`define FSP_OP_READ_STATUS 4'h2
`define FSP_OP_CLR_STATUS  4'h3
`define FSP_OP_SUSPEND     4'h4
`define FSP_OP_RESUME      4'h5
`define FSP_OP_PROTECT     4'h6
`define FSP_OP_UNPROTECT   4'h7
`define FSP_OP_READ_ID     4'h8
`define FSP_OP_RESET       4'h9
`define FSP_OP_READ        4'ha
`define FSP_OP_POWER_DOWN  4'hb
`define FSP_OP_POWER_UP    4'hc

// device command bytes
`define FSP_CMD_UNLOCK1    8'haa
`define FSP_CMD_UNLOCK2    8'h55
`define FSP_ADR_UNLOCK1    20'h05555
`define FSP_ADR_UNLOCK2    20'h02aaa
`define FSP_CMD_SETUP      8'h60
`define FSP_CMD_LOCK       8'h20
`define FSP_CMD_UNLOCK_SEC 8'h40
`define FSP_CMD_SUSPEND    8'hb0
`define FSP_CMD_RESUME     8'hd0
`define FSP_CMD_RD_STATUS  8'h70
`define FSP_CMD_CLR_STATUS 8'h50
`define FSP_CMD_RD_ARRAY   8'hf0
`define FSP_CMD_READ_ID    8'h90

// status bits
`define FSP_ST_READY       7
`define FSP_ST_SUSPEND     6
`define FSP_ST_ERASE_FAIL  5
`define FSP_ST_PROG_FAIL   4
`define FSP_ST_POLL_MASK   8'hf0

// bus timing: strobe low and gap, in ns, and counts at 50 MHz
`define FSP_CLK_NS         20
`define FSP_STROBE_NS      100
`define FSP_STROBE_CYC     ((`FSP_STROBE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// ===== verilog/fsp_host.v
/*
 * host controller driving a parallel NOR flash over its async pins:
 * command sequences, status and data reads, and the power-down pin.
 * assumes: one 50 MHz clock; software on a plain address/strobe port;
 * flash data pins resolved by the testbench from the enables.
 */
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "fsp_regs.vh"

module fsp_host (
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// software register port
	input  wire [3:0]  sw_addr,
	input  wire [31:0] sw_wdata,
	input  wire        sw_write,
	input  wire        sw_read,
	output reg  [31:0] sw_rdata,
	// flash pins
	output reg  [19:0] flash_addr,
	output reg  [15:0] flash_dq_out,
	output reg  [15:0] flash_dq_oe_n,
	input  wire [15:0] flash_dq_in,
	output reg         flash_ce_n,
	output reg         flash_oe_n,
	output reg         flash_we_n,
	output reg         flash_byte_n,
	output reg         flash_wp,
	output reg         power_down_n
);

	// sequencer states, one-hot
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_WLOW  = 5'h02;
	localparam [4:0] ST_WHIGH = 5'h04;
	localparam [4:0] ST_RLOW  = 5'h08;
	localparam [4:0] ST_RHIGH = 5'h10;
	localparam integer STROBE_N = `FSP_STROBE_CYC;  // strobe length, cycles
	localparam [7:0] STROBE   = STROBE_N[7:0];

	reg [4:0]  state;          // sequencer state
	reg [7:0]  timer;          // strobe timing counter
	reg [2:0]  step;           // cycle index within sequence
	reg [2:0]  last_step;      // final cycle index of sequence
	reg [3:0]  op;             // operation being run
	reg [19:0] op_addr;        // target address from software
	reg [15:0] op_wdata;       // spare data register
	reg [7:0]  status;         // last status byte read
	reg [15:0] rdata;          // last raw read word
	reg        status_mode;    // host view: device shows status
	reg        id_mode;        // host view: device in id mode
	reg        erasing;        // software says a sector erase runs
	reg        suspended;      // host view of suspend
	reg [15:0] dq_s1, dq_s2, dq_s3;  // pin synchroniser
	reg [15:0] dq_sync;        // pin data once stages agree
	reg        busy;           // sequence in flight
	reg        rejected;       // last order refused locally

	// command byte and address for a given cycle of an operation
	function [27:0] seq_cycle;
		input [3:0]  f_op;
		input [2:0]  f_step;
		input [19:0] f_addr;
		begin
			case (f_op)
			`FSP_OP_PROTECT, `FSP_OP_UNPROTECT: begin
				// unlock, unlock, setup, unlock, unlock, final
				case (f_step)
				3'h0, 3'h3: seq_cycle = {`FSP_ADR_UNLOCK1, `FSP_CMD_UNLOCK1};
				3'h1, 3'h4: seq_cycle = {`FSP_ADR_UNLOCK2, `FSP_CMD_UNLOCK2};
				3'h2: seq_cycle = {`FSP_ADR_UNLOCK1, `FSP_CMD_SETUP};
				default: begin
					// sector in the top four address bits
					seq_cycle = {f_addr[19:16], 16'h0000,
						(f_op == `FSP_OP_PROTECT) ?
						`FSP_CMD_LOCK : `FSP_CMD_UNLOCK_SEC};
				end
				endcase
			end
			`FSP_OP_READ_ID, `FSP_OP_RESET: begin
				case (f_step)
				3'h0: seq_cycle = {`FSP_ADR_UNLOCK1, `FSP_CMD_UNLOCK1};
				3'h1: seq_cycle = {`FSP_ADR_UNLOCK2, `FSP_CMD_UNLOCK2};
				default: seq_cycle = {`FSP_ADR_UNLOCK1,
					(f_op == `FSP_OP_RESET) ?
					`FSP_CMD_RD_ARRAY : `FSP_CMD_READ_ID};
				endcase
			end
			`FSP_OP_READ_STATUS: seq_cycle = {f_addr, `FSP_CMD_RD_STATUS};
			`FSP_OP_CLR_STATUS: seq_cycle = {f_addr, `FSP_CMD_CLR_STATUS};
			`FSP_OP_SUSPEND: seq_cycle = {f_addr, `FSP_CMD_SUSPEND};
			`FSP_OP_RESUME: seq_cycle = {f_addr, `FSP_CMD_RESUME};
			default: seq_cycle = {f_addr, `FSP_CMD_RD_ARRAY};
			endcase
		end
	endfunction

	// last cycle index per operation
	function [2:0] seq_len;
		input [3:0] f_op;
		begin
			case (f_op)
			`FSP_OP_PROTECT, `FSP_OP_UNPROTECT: seq_len = 3'h5;
			`FSP_OP_READ_ID, `FSP_OP_RESET: seq_len = 3'h2;
			default: seq_len = 3'h0;
			endcase
		end
	endfunction

	wire [27:0] first_cycle = seq_cycle(sw_wdata[3:0], 3'h0, op_addr);
	wire [27:0] next_cycle  = seq_cycle(op, step + 3'h1, op_addr);

	// whether an order may be issued in the host's current view
	wire order_ok =
		~power_down_n ? (sw_wdata[3:0] == `FSP_OP_POWER_UP) :
		(sw_wdata[3:0] == `FSP_OP_SUSPEND) ? erasing & ~suspended :
		(sw_wdata[3:0] == `FSP_OP_RESUME) ? suspended :
		suspended ? (sw_wdata[3:0] == `FSP_OP_READ_ARRAY ||
			sw_wdata[3:0] == `FSP_OP_READ_STATUS ||
			sw_wdata[3:0] == `FSP_OP_READ ||
			sw_wdata[3:0] == `FSP_OP_POWER_DOWN) :
		(sw_wdata[3:0] == `FSP_OP_RESET) ? ~erasing :
		((sw_wdata[3:0] == `FSP_OP_PROTECT ||
			sw_wdata[3:0] == `FSP_OP_UNPROTECT) ?
			~(status[`FSP_ST_ERASE_FAIL] | status[`FSP_ST_PROG_FAIL]) :
			1'b1);

	// pin data synchroniser, three stages; stages two and three agree
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
			dq_s3 <= 16'h0000;
			dq_sync <= 16'h0000;
		end else begin
			dq_s1 <= flash_dq_in;
			dq_s2 <= dq_s1;
			dq_s3 <= dq_s2;
			dq_sync <= (dq_s3 & ~(dq_s2 ^ dq_s3)) |  // bit moves when 2, 3 agree
				(dq_sync & (dq_s2 ^ dq_s3));
		end
	end

	// software register writes, order launch and flash sequencer
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state         <= ST_IDLE;
			timer         <= 8'h00;
			step          <= 3'h0;
			last_step     <= 3'h0;
			op            <= 4'h0;
			op_addr       <= 20'h00000;
			op_wdata      <= 16'h0000;
			status        <= 8'h00;
			rdata         <= 16'h0000;
			status_mode   <= 1'b0;  // array read after power-up
			id_mode       <= 1'b0;
			erasing       <= 1'b0;
			suspended     <= 1'b0;
			busy          <= 1'b0;
			rejected      <= 1'b0;
			flash_addr    <= 20'h00000;
			flash_dq_out  <= 16'h0000;
			flash_dq_oe_n <= 16'hffff;
			flash_ce_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_byte_n  <= 1'b1;
			flash_wp      <= 1'b1;
			power_down_n  <= 1'b1;
		end else begin
			// configuration registers, accepted any time
			if (sw_write && sw_addr == `FSP_REG_ADDR)
				op_addr <= sw_wdata[19:0];
			if (sw_write && sw_addr == `FSP_REG_WDATA)
				op_wdata <= sw_wdata[15:0];
			if (sw_write && sw_addr == `FSP_REG_FLAGS) begin
				erasing      <= sw_wdata[0];
				flash_wp     <= sw_wdata[1];  // protect change needs high
				flash_byte_n <= sw_wdata[2];
			end
			case (state)
			ST_IDLE: begin
				if (sw_write && sw_addr == `FSP_REG_CTRL) begin
					rejected <= ~order_ok;
					if (order_ok) begin
						op <= sw_wdata[3:0];
						step <= 3'h0;
						last_step <= seq_len(sw_wdata[3:0]);
						timer <= STROBE;
						case (sw_wdata[3:0])
						`FSP_OP_POWER_DOWN: begin
							// aborts any erase and clears status
							power_down_n <= 1'b0;
							status <= 8'h00;
							suspended <= 1'b0;
							erasing <= 1'b0;
						end
						`FSP_OP_POWER_UP: begin
							power_down_n <= 1'b1;
							status_mode <= 1'b0;  // wake in array read
							id_mode <= 1'b0;
						end
						`FSP_OP_READ: begin
							busy <= 1'b1;
							state <= ST_RLOW;
							flash_addr <= op_addr;
							flash_ce_n <= 1'b0;
							flash_oe_n <= 1'b0;  // falling edge latches the read value
						end
						default: begin
							busy <= 1'b1;
							state <= ST_WLOW;
							flash_ce_n <= 1'b0;
							flash_we_n <= 1'b0;
							flash_addr <= first_cycle[27:8];
							flash_dq_out <= {8'h00, first_cycle[7:0]};
							flash_dq_oe_n <= 16'h0000;
						end
						endcase
					end
				end
			end
			ST_WLOW: begin
				if (timer == 8'h01) begin
					// rising write edge latches data, starts operation
					flash_we_n <= 1'b1;
					flash_ce_n <= 1'b1;
					timer <= STROBE;
					state <= ST_WHIGH;
				end else
					timer <= timer - 8'h01;
			end
			ST_WHIGH: begin
				if (timer != 8'h01)
					timer <= timer - 8'h01;
				else if (step != last_step) begin
					step <= step + 3'h1;
					timer <= STROBE;
					state <= ST_WLOW;
					flash_ce_n <= 1'b0;
					flash_we_n <= 1'b0;
					flash_addr <= next_cycle[27:8];  // next cycle's address
					flash_dq_out <= {8'h00, next_cycle[7:0]};
				end else begin
					flash_dq_oe_n <= 16'hffff;
					busy <= 1'b0;
					state <= ST_IDLE;
					case (op)
					`FSP_OP_READ_ARRAY, `FSP_OP_RESET: begin
						status_mode <= 1'b0;
						id_mode <= 1'b0;
					end
					`FSP_OP_READ_ID: id_mode <= 1'b1;
					`FSP_OP_SUSPEND: begin
						suspended <= 1'b1;
						status_mode <= 1'b1;
					end
					`FSP_OP_RESUME: suspended <= 1'b0;
					`FSP_OP_CLR_STATUS: status <= 8'h00;
					default: status_mode <= 1'b1;
					endcase
				end
			end
			ST_RLOW: begin
				if (timer == 8'h01) begin
					// sample once the synchroniser has settled
					rdata <= dq_sync;
					if (status_mode)
						status <= dq_sync[7:0] & `FSP_ST_POLL_MASK;
					flash_oe_n <= 1'b1;  // release so next read re-latches
					flash_ce_n <= 1'b1;
					timer <= STROBE;
					state <= ST_RHIGH;
				end else
					timer <= timer - 8'h01;
			end
			ST_RHIGH: begin
				if (timer == 8'h01) begin
					busy <= 1'b0;
					state <= ST_IDLE;
				end else
					timer <= timer - 8'h01;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// register read data, one cycle after the read strobe
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sw_rdata <= 32'h00000000;
		else if (sw_read) begin
			case (sw_addr)
			`FSP_REG_CTRL: sw_rdata <= {24'h000000, rejected, busy,
				suspended, status_mode, op};
			`FSP_REG_ADDR: sw_rdata <= {12'h000, op_addr};
			`FSP_REG_WDATA: sw_rdata <= {16'h0000, op_wdata};
			`FSP_REG_STATUS: sw_rdata <= {24'h000000, status};
			`FSP_REG_RDATA: sw_rdata <= {16'h0000, rdata};
			`FSP_REG_FLAGS: sw_rdata <= {27'h0000000, id_mode, ~power_down_n,
				flash_byte_n, flash_wp, erasing};
			default: sw_rdata <= 32'h00000000;
			endcase
		end else
			sw_rdata <= 32'h00000000;
	end

endmodule // fsp_host

// ===== tb/fsp_host_checker.sv
/* assertions on the flash pins of the host controller.
 * assumes: bound to fsp_host; one clock, async active-low reset. */
`timescale 1ns/1ps
module fsp_host_checker (
	// clock and reset
	input wire        clk,
	input wire        reset_n,
	// flash pins
	input wire [19:0] flash_addr,
	input wire [15:0] flash_dq_out,
	input wire [15:0] flash_dq_oe_n,
	input wire        flash_ce_n,
	input wire        flash_oe_n,
	input wire        flash_we_n,
	input wire        power_down_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// one write pulse: five cycles low, then high
	sequence s_we_pulse;
		!flash_we_n [*5] ##1 flash_we_n;
	endsequence
	// one read pulse: five cycles low, then high
	sequence s_oe_pulse;
		!flash_oe_n [*5] ##1 flash_oe_n;
	endsequence
	a_write_oe_high: assert property (!flash_we_n |-> flash_oe_n && !flash_ce_n)
		else $error("write strobe with output enable low");
	a_we_pulse: assert property ($fell(flash_we_n) |-> s_we_pulse)
		else $error("write pulse length wrong");
	a_oe_toggle: assert property ($fell(flash_oe_n) |-> s_oe_pulse)
		else $error("read strobe not toggled per read");
	a_read_ce_low: assert property (!flash_oe_n |-> !flash_ce_n && flash_dq_oe_n == 16'hffff)
		else $error("read without chip enable or with bus driven");
	a_cmd_stable: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr))
		else $error("command or address moved in write pulse");
	a_cmd_driven: assert property (!flash_we_n |-> flash_dq_oe_n[7:0] == 8'h00)
		else $error("command byte not driven");
	a_setup_order: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'h60 |-> $past(flash_dq_out[7:0], 10) == 8'h55 && $past(flash_dq_out[7:0], 20) == 8'haa)
		else $error("setup byte without unlock pair");
	a_lock_order: assert property ($fell(flash_we_n) && (flash_dq_out[7:0] == 8'h20 || flash_dq_out[7:0] == 8'h40) |-> $past(flash_dq_out[7:0], 30) == 8'h60 && $past(flash_addr, 10) == 20'h02aaa)
		else $error("lock byte out of sequence");
	a_pd_quiet: assert property (!power_down_n |-> flash_ce_n && flash_we_n && flash_oe_n)
		else $error("strobes active in power-down");
endmodule // fsp_host_checker
bind fsp_host fsp_host_checker fsp_host_checker_inst (.clk(clk),
	.reset_n(reset_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
	.flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
	.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
	.power_down_n(power_down_n));

// ===== tb/fsp_flash_model.sv
/* flash device model: status, suspend, protect, id, power-down.
 * assumes: host pins as inputs; the bench resolves the data bus. */
`timescale 1ns/1ps
module fsp_flash_model #(
	parameter MAKER = 16'h0011, // arbitrary identity value
	parameter DEVID = 16'h0022, // arbitrary identity value
	parameter OP_NS = 2000      // lock and suspend time
) (
	// host side pins
	input  wire [19:0] addr,
	input  wire [15:0] dq,
	input  wire        ce_n,
	input  wire        oe_n,
	input  wire        we_n,
	input  wire        byte_n,
	input  wire        wp,
	input  wire        power_down_n,
	// data drive
	output reg  [15:0] dev_dq,
	output reg  [15:0] dev_en
);
	reg  [7:0]  st = 8'h80;  // status byte
	reg  [1:0]  mode = 0;    // 0 array, 1 status, 2 id
	reg  [2:0]  seq = 0;     // unlock position
	reg  [15:0] prot = 0;    // sector protect bits
	reg  [19:0] la;          // address of last write
	reg         erasing = 0; // sector erase runs
	reg         bad;         // erase ends failed
	integer     left;        // erase ticks left
	wire [7:0]  c = dq[7:0]; // command byte
	// erase start, stands in for the erase sequence
	task begin_erase(input f, input [3:0] s);
		if (!st[5] && !prot[s]) begin  // protected sectors never erased
			erasing = 1;
			bad = f;
			left = 1000;
			st[7] = 0;
			mode = 1;
		end
	endtask
	// erase runs unless suspended; fail bit only ever set
	always #10 if (erasing && !st[6] && power_down_n) begin
		left = left - 1;
		if (left == 0) begin
			erasing = 0;
			st[7] = 1;
			st[5] = st[5] | bad;
		end
	end
	// a write runs while chip enable and write strobe are both low
	wire        w_act = (we_n === 1'b0) && (ce_n === 1'b0) && (oe_n === 1'b1);
	reg         w_on = 0;    // write cycle under way
	// address latched just after the later falling strobe
	always @(posedge w_act) begin
		w_on = 1;
		#1 la = addr;
	end
	// commands taken on the first rising strobe of the pair
	always @(negedge w_act) if (w_on && power_down_n) begin
		w_on = 0;
		if (!st[6] || c == 8'hf0 || c == 8'h70 || c == 8'hd0)
			case (c)
			8'h20, 8'h40: if (seq == 5 && wp) begin
				st[7] = 0;
				mode = 1;
				st[7] <= #OP_NS 1'b1;
				prot[la[19:16]] <= #OP_NS c == 8'h20;
			end
			8'h70: mode = 1;
			8'h50: st[5:4] = 2'b00;
			8'hb0: if (erasing) begin
				st[6] = 1;
				mode = 1;
				st[7] <= #OP_NS 1'b1;
			end
			8'hd0: if (st[6]) st[7:6] = 2'b00;
			8'hf0: if (st[7] && !(erasing && !st[6])) mode = 0;
			8'h90: mode = 2;
			default: ;
			endcase
		seq = (c == 8'haa || c == 8'h55 || c == 8'h60) ? seq + 1 : 0;
	end
	// power-down aborts and clears status
	always @(negedge power_down_n) begin
		erasing = 0;
		st = 8'h80;
		mode = 0;
	end
	// value latched on the later falling read strobe
	always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n)
		case (mode)
		2'd1: dev_dq = {8'h00, st[7:4], 4'h0};
		2'd2: dev_dq = addr[1:0] == 2'b00 ? MAKER : addr[1:0] == 2'b01 ?
			DEVID : prot[addr[19:16]] ? MAKER : 16'h0000;
		default: dev_dq = addr[15:0] ^ 16'h5a5a;
		endcase
	// drive while read strobes low; byte mode floats 8 to 15
	always @* dev_en = (!oe_n && !ce_n && we_n && power_down_n)
		? (byte_n ? 16'hffff : 16'h00ff) : 16'h0000;
endmodule // fsp_flash_model

// ===== tb/fsp_host_tb.sv
/* bench of the flash host controller: software port tasks, device
 * model on the flash pins, data bus resolved here.
 * assumes: 50 MHz clock, reset held low for ten cycles. */
`timescale 1ns/1ps
`include "fsp_regs.vh"
module fsp_host_tb;
	localparam MAKER = 16'h0011;            // arbitrary identity value
	localparam DEVID = 16'h0022;            // arbitrary identity value
	localparam ARRAY = 32'h2345 ^ 32'h5a5a; // model data at 12345
	reg         clk = 0, reset_n = 0, sw_write = 0, sw_read = 0;
	reg  [3:0]  sw_addr = 0;   // register index
	reg  [31:0] sw_wdata = 0;  // write data
	wire [31:0] sw_rdata;      // read data
	wire [19:0] flash_addr;    // address pins
	wire [15:0] flash_dq_out, flash_dq_oe_n, flash_dq_in, dev_dq, dev_en;
	wire        flash_ce_n, flash_oe_n, flash_we_n;
	wire        flash_byte_n, flash_wp, power_down_n;
	reg  [15:0] dq_last = 0;   // last bus level
	reg  [31:0] v;             // value read back
	integer     error_cnt = 0, checked = 0, i;
	// undriven bits show the inverse of the last level
	assign flash_dq_in = (~flash_dq_oe_n & flash_dq_out) | (dev_en & dev_dq)
		| (flash_dq_oe_n & ~dev_en & ~dq_last);
	always #10 clk = ~clk;
	always @(posedge clk) dq_last <= reset_n ? flash_dq_in : 16'h0000;
	fsp_host fsp_host_inst (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
		.sw_rdata(sw_rdata), .flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
		.flash_byte_n(flash_byte_n), .flash_wp(flash_wp),
		.power_down_n(power_down_n));
	fsp_flash_model #(.MAKER(MAKER), .DEVID(DEVID), .OP_NS(2000))
		fsp_flash_model_inst (.addr(flash_addr), .dq(flash_dq_in),
		.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.byte_n(flash_byte_n), .wp(flash_wp), .power_down_n(power_down_n),
		.dev_dq(dev_dq), .dev_en(dev_en));
	// verdict and end of run
	task report_and_stop;
		begin
			if (error_cnt == 0 && checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// compare seen with expected
	task chk(input [63:0] name, input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %0s exp %h got %h", name, exp, got);
			end
		end
	endtask
	// one-cycle register write
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			sw_addr <= a;
			sw_wdata <= d;
			sw_write <= 1;
			@(posedge clk);
			sw_write <= 0;
		end
	endtask
	// register read, data taken in the following cycle
	task rd(input [3:0] a, output [31:0] d);
		begin
			@(posedge clk);
			sw_addr <= a;
			sw_read <= 1;
			@(posedge clk);
			sw_read <= 0;
			#1 d = sw_rdata;
		end
	endtask
	// order an operation, poll busy under a bound
	task op(input [3:0] code);
		begin
			wr(`FSP_REG_CTRL, {28'h0, code});
			v = 32'h40;
			for (i = 0; i < 100 && v[6] !== 1'b0; i = i + 1)
				rd(`FSP_REG_CTRL, v);
			if (v[6] !== 1'b0) begin
				error_cnt = error_cnt + 1;
				report_and_stop;
			end
		end
	endtask
	// status read: status command, then a read cycle
	task rdst(input [31:0] e);
		begin
			op(`FSP_OP_READ_STATUS);
			op(`FSP_OP_READ);
			rd(`FSP_REG_STATUS, v);
			chk("status", v, e);
		end
	endtask
	// data read at an address, low word compared
	task rda(input [31:0] a, input [31:0] e);
		begin
			wr(`FSP_REG_ADDR, a);
			op(`FSP_OP_READ);
			rd(`FSP_REG_RDATA, v);
			chk("rdata", v & 32'hffff, e);
		end
	endtask
	// an order that must be refused
	task rej(input [3:0] code);
		begin
			op(code);
			rd(`FSP_REG_CTRL, v);
			chk("refused", v & 32'h80, 32'h80);
		end
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1;
		wr(`FSP_REG_FLAGS, 32'h6);
		rda(32'h12345, ARRAY);
		rdst(32'h80);
		rej(`FSP_OP_SUSPEND);
		fsp_flash_model_inst.begin_erase(1'b1, 4'h0);
		wr(`FSP_REG_FLAGS, 32'h7);
		op(`FSP_OP_SUSPEND);
		rdst(32'h40);
		repeat (110) @(posedge clk);
		rdst(32'hc0);
		rej(`FSP_OP_PROTECT);
		op(`FSP_OP_RESUME);
		rdst(32'h00);
		rej(`FSP_OP_RESUME);
		repeat (600) @(posedge clk);
		rdst(32'ha0);
		wr(`FSP_REG_FLAGS, 32'h6);
		rej(`FSP_OP_PROTECT);
		op(`FSP_OP_CLR_STATUS);
		rdst(32'h80);
		wr(`FSP_REG_ADDR, 32'h50000);
		op(`FSP_OP_PROTECT);
		rdst(32'h00);
		repeat (110) @(posedge clk);
		rdst(32'h80);
		op(`FSP_OP_READ_ID);
		rda(32'h0, MAKER);
		rda(32'h1, DEVID);
		rda(32'h50002, MAKER);
		rda(32'h60002, 0);
		op(`FSP_OP_RESET);
		rda(32'h12345, ARRAY);
		wr(`FSP_REG_ADDR, 32'h50000);
		op(`FSP_OP_UNPROTECT);
		repeat (110) @(posedge clk);
		rdst(32'h80);
		wr(`FSP_REG_FLAGS, 32'h4);
		wr(`FSP_REG_ADDR, 32'h60000);
		rd(`FSP_REG_ADDR, v);
		chk("addr", v, 32'h60000);
		op(`FSP_OP_PROTECT);
		repeat (110) @(posedge clk);
		wr(`FSP_REG_FLAGS, 32'h6);
		op(`FSP_OP_READ_ID);
		rda(32'h50002, 0);
		rda(32'h60002, 0);
		wr(`FSP_REG_FLAGS, 32'h2);
		rdst(32'h80);
		wr(`FSP_REG_FLAGS, 32'h7);
		fsp_flash_model_inst.begin_erase(1'b0, 4'h0);
		op(`FSP_OP_POWER_DOWN);
		rd(`FSP_REG_FLAGS, v);
		chk("flags", v & 32'h9, 32'h8);
		rd(`FSP_REG_STATUS, v);
		chk("status", v, 32'h0);
		op(`FSP_OP_POWER_UP);
		wr(`FSP_REG_FLAGS, 32'h6);
		rda(32'h12345, ARRAY);
		rdst(32'h80);
		report_and_stop;
	end
endmodule // fsp_host_tb
